/* File: verilog/codec_cfg_pkg.sv */
// Purpose: Shared constants and carriers for the channel configuration bank.
// Assumes: Command codes double as register indexes; byte address is four times the code.
// Notes:   Bit 0 of a code picks write (0) or read (1).
package codec_cfg_pkg;

  localparam int N_CH   = 4;
  localparam int N_PIN  = 5;
  localparam int ADDR_W = 10;
  localparam int IDX_LSB = 2;

  localparam logic [7:0] CMD_CHAN_EN     = 8'h4a;
  localparam logic [7:0] CMD_RT_READ     = 8'h4d;
  localparam logic [7:0] CMD_RT_READ_CLR = 8'h4f;
  localparam logic [7:0] CMD_GAIN_ISN    = 8'h50;
  localparam logic [7:0] CMD_IO_DATA     = 8'h52;
  localparam logic [7:0] CMD_IO_DIR      = 8'h54;
  localparam logic [7:0] CMD_OP_FUNC     = 8'h60;
  localparam logic [7:0] CMD_INT_MASK    = 8'h6c;
  localparam logic [7:0] CMD_OP_COND     = 8'h70;

  localparam int GAIN_ATTEN_DIS = 7;
  localparam int GAIN_TX        = 6;
  localparam int GAIN_RX        = 5;
  localparam int IO_MUX_BIT     = 5;
  localparam int DIR_CHANNEL_ACTIVE_FLAG      = 6;
  localparam int DIR_CLOCK_SYNC_FAIL_FLAG      = 5;
  localparam int OF_LINEAR      = 7;
  localparam int OF_MULAW       = 6;
  localparam int OC_TX_CUT      = 7;
  localparam int OC_RX_CUT      = 6;
  localparam int OC_HPF_BYP     = 5;
  localparam int OC_RX_LOSS     = 4;
  localparam int OC_TX_ARM      = 3;
  localparam int OC_TSA_LB      = 2;
  localparam int OC_FULL_LB     = 1;
  localparam int OC_TONE        = 0;
  localparam int FILT_B         = 0;

  localparam logic [4:0] ISN_CUTOFF_CODE   = 5'h00;
  localparam logic [4:0] ISN_LOOPBACK_CODE = 5'h10;
  localparam logic [5:0] ISN_OFFSET        = 6'h10;

  localparam logic [7:0]      RST_REG      = 8'h00;
  localparam logic [7:0]      RST_INT_MASK = 8'hff;
  localparam logic [N_CH-1:0] RST_CHAN_EN  = 4'hf;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded per-channel controls; isn_gain counts in steps of 1/16 of the attenuator gain.
  typedef struct packed {
    logic             input_atten_on;
    logic             tx_gain_6db;
    logic             rx_loss_6db;
    logic signed [5:0] isn_gain;
    logic             isn_cutoff;
    logic             full_digital_loopback;
    logic             linear_coding;
    logic             mu_law;
    logic [5:0]       filter_programmed;
    logic             tx_path_on;
    logic             rx_path_on;
    logic             b_filter_on;
    logic             tx_highpass_on;
    logic             rx_extra_loss;
    logic             tx_interrupt_arm;
    logic             slot_assigner_loopback;
    logic             rx_test_tone;
  } chan_ctrl_t;

  typedef struct packed {
    logic [N_PIN-1:0] value;
    logic [N_PIN-1:0] enable;
    logic             pin_one_mux_second_bit;
  } line_io_drive_t;

endpackage

/* File: verilog/sync_2ff.sv */
// Purpose: Two flip-flop synchroniser for asynchronous levels.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage may be read.
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

/* File: verilog/realtime_change_irq.sv */
// Purpose: Pulls a low-active interrupt when an unmasked real-time bit changes.
// Assumes: Data is already synchronised to clk_sys_i.
// Notes:   A change in the clearing cycle keeps the interrupt asserted.
`timescale 1ns/1ps
module realtime_change_irq (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] data_i,
  input  wire logic [7:0] mask_i,
  input  wire logic       clear_i,
  output logic            irq_n_o
);
  logic [7:0] prev_q;
  logic       hit;

  assign hit = |((data_i ^ prev_q) & ~mask_i);

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      prev_q  <= 8'h00;
      irq_n_o <= 1'b1;
    end else begin
      prev_q  <= data_i;
      if (hit) begin
        irq_n_o <= 1'b0;
      end else if (clear_i) begin
        irq_n_o <= 1'b1;
      end
    end
  end
endmodule

/* File: verilog/codec_channel_config_regs.sv */
// Purpose: Per-channel configuration and status bank of a four-channel codec, AXI4-Lite slave.
// Assumes: Register index equals its command code; byte address is four times the index.
// Notes:   Writes go to every enabled channel; reads answer from the lowest enabled one.
`timescale 1ns/1ps
module codec_channel_config_regs (
  input  wire logic                                 clk_sys_i,
  input  wire logic                                 reset_i,
  input  wire logic [codec_cfg_pkg::ADDR_W-1:0]     s_axi_awaddr_i,
  input  wire logic                                 s_axi_awvalid_i,
  output logic                                      s_axi_awready_o,
  input  wire logic [31:0]                          s_axi_wdata_i,
  input  wire logic [3:0]                           s_axi_wstrb_i,
  input  wire logic                                 s_axi_wvalid_i,
  output logic                                      s_axi_wready_o,
  output logic [1:0]                                s_axi_bresp_o,
  output logic                                      s_axi_bvalid_o,
  input  wire logic                                 s_axi_bready_i,
  input  wire logic [codec_cfg_pkg::ADDR_W-1:0]     s_axi_araddr_i,
  input  wire logic                                 s_axi_arvalid_i,
  output logic                                      s_axi_arready_o,
  output logic [31:0]                               s_axi_rdata_o,
  output logic [1:0]                                s_axi_rresp_o,
  output logic                                      s_axi_rvalid_o,
  input  wire logic                                 s_axi_rready_i,
  input  wire logic                                 e1_multiplex_enable_i,
  input  wire logic [codec_cfg_pkg::N_CH-1:0]       channel_active_i,
  input  wire logic                                 clock_sync_fail_i,
  input  wire logic [2*codec_cfg_pkg::N_CH-1:0]     realtime_pin_i,
  output codec_cfg_pkg::chan_ctrl_t                 chan_ctrl_o [codec_cfg_pkg::N_CH],
  output codec_cfg_pkg::line_io_drive_t             line_io_drive_o [codec_cfg_pkg::N_CH],
  output logic                                      realtime_irq_n_o
);
  import codec_cfg_pkg::*;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_t;

  wr_state_t          wr_state_q;
  wr_state_t          wr_state_d;
  rd_state_t          rd_state_q;
  rd_state_t          rd_state_d;
  logic [ADDR_W-1:0]  aw_addr_q;
  logic               aw_have_q;
  logic               aw_have_d;
  logic               w_have_q;
  logic               w_have_d;
  logic [7:0]         w_byte_q;
  logic               w_lane0_q;
  logic               awready_q;
  logic               wready_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic               arready_q;
  logic               rvalid_q;
  logic [31:0]        rdata_q;
  logic [1:0]         rresp_q;

  logic [N_CH-1:0]    chen_q;
  logic [7:0]         mask_q;
  logic [7:0]         gain_q  [N_CH];
  logic [5:0]         iodat_q [N_CH];
  logic [N_PIN-1:0]   dir_q   [N_CH];
  logic [7:0]         func_q  [N_CH];
  logic [7:0]         cond_q  [N_CH];
  chan_ctrl_t         ctrl_q  [N_CH];
  line_io_drive_t     drive_q [N_CH];

  // Synchronised pin levels: bits 7:0 real-time data, bit 8 clock fail.
  logic [8:0]         pins_sync;
  logic [7:0]         rt_data;
  logic               clock_sync_fail_flag;

  sync_2ff #(
    .WIDTH (9)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .async_i   ({clock_sync_fail_i, realtime_pin_i}),
    .sync_o    (pins_sync)
  );

  assign rt_data = pins_sync[7:0];
  assign clock_sync_fail_flag   = pins_sync[8];

  // Write channel.
  wire        aw_hs    = s_axi_awvalid_i & awready_q;
  wire        w_hs     = s_axi_wvalid_i & wready_q;
  wire        do_write = (wr_state_q == WR_COLLECT) & aw_have_q & w_have_q;
  wire [7:0]  wr_cmd   = aw_addr_q[IDX_LSB+7:IDX_LSB];
  wire        wr_align = (aw_addr_q[IDX_LSB-1:0] == 2'h0);
  wire        wr_is_wr = ~wr_cmd[0];
  wire        wr_sel_chen = (wr_cmd == CMD_CHAN_EN);
  wire        wr_sel_gain = (wr_cmd == CMD_GAIN_ISN);
  wire        wr_sel_iod  = (wr_cmd == CMD_IO_DATA);
  wire        wr_sel_dir  = (wr_cmd == CMD_IO_DIR);
  wire        wr_sel_func = (wr_cmd == CMD_OP_FUNC);
  wire        wr_sel_mask = (wr_cmd == CMD_INT_MASK);
  wire        wr_sel_cond = (wr_cmd == CMD_OP_COND);
  wire        wr_mapped   = wr_sel_chen | wr_sel_gain | wr_sel_iod | wr_sel_dir
                          | wr_sel_func | wr_sel_mask | wr_sel_cond;
  wire        wr_ok    = wr_align & wr_is_wr & wr_mapped;
  wire        wr_en    = do_write & wr_ok & w_lane0_q;

  always_comb begin
    case (wr_state_q)
      WR_COLLECT: wr_state_d = do_write ? WR_RESP : WR_COLLECT;
      WR_RESP:    wr_state_d = s_axi_bready_i ? WR_COLLECT : WR_RESP;
      default:    wr_state_d = WR_COLLECT;
    endcase
  end

  assign aw_have_d = ~do_write & (aw_have_q | aw_hs);
  assign w_have_d  = ~do_write & (w_have_q | w_hs);

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_state_q <= WR_COLLECT;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      aw_addr_q  <= '0;
      w_byte_q   <= 8'h00;
      w_lane0_q  <= 1'b0;
    end else begin
      wr_state_q <= wr_state_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      awready_q  <= (wr_state_d == WR_COLLECT) & ~aw_have_d;
      wready_q   <= (wr_state_d == WR_COLLECT) & ~w_have_d;
      bvalid_q   <= (wr_state_d == WR_RESP);
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        w_byte_q  <= s_axi_wdata_i[7:0];
        w_lane0_q <= s_axi_wstrb_i[0];
      end
      if (do_write) begin
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Global registers do not depend on the channel enables.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      chen_q <= RST_CHAN_EN;
      mask_q <= RST_INT_MASK;
    end else begin
      if (wr_en & wr_sel_chen) begin
        chen_q <= w_byte_q[N_CH-1:0];
      end
      if (wr_en & wr_sel_mask) begin
        mask_q <= w_byte_q;
      end
    end
  end

  // Read channel.
  wire        ar_hs    = s_axi_arvalid_i & arready_q;
  wire [7:0]  rd_cmd   = s_axi_araddr_i[IDX_LSB+7:IDX_LSB];
  wire [7:0]  rd_base  = {rd_cmd[7:1], 1'b0};
  wire        rd_align = (s_axi_araddr_i[IDX_LSB-1:0] == 2'h0);
  wire        rd_is_rd = rd_cmd[0];
  wire        rd_rt      = (rd_cmd == CMD_RT_READ) | (rd_cmd == CMD_RT_READ_CLR);
  wire        rd_sel_chen = (rd_base == CMD_CHAN_EN);
  wire        rd_sel_gain = (rd_base == CMD_GAIN_ISN);
  wire        rd_sel_iod  = (rd_base == CMD_IO_DATA);
  wire        rd_sel_dir  = (rd_base == CMD_IO_DIR);
  wire        rd_sel_func = (rd_base == CMD_OP_FUNC);
  wire        rd_sel_mask = (rd_base == CMD_INT_MASK);
  wire        rd_sel_cond = (rd_base == CMD_OP_COND);
  wire        rd_mapped   = rd_rt | rd_sel_chen | rd_sel_gain | rd_sel_iod | rd_sel_dir
                          | rd_sel_func | rd_sel_mask | rd_sel_cond;
  wire        rd_ok    = rd_align & rd_is_rd & rd_mapped;
  wire        rt_clear = ar_hs & rd_align & (rd_cmd == CMD_RT_READ_CLR);
  wire        any_en   = |chen_q;
  wire [1:0]  rd_ch    = chen_q[0] ? 2'h0 : chen_q[1] ? 2'h1 : chen_q[2] ? 2'h2 : 2'h3;
  wire        channel_active_flag    = any_en & channel_active_i[rd_ch];
  wire [7:0]  dir_rd   = {1'b0, channel_active_flag, clock_sync_fail_flag, any_en ? dir_q[rd_ch] : 5'h00};
  wire [7:0]  ch_rd    = rd_sel_gain ? gain_q[rd_ch]
                       : rd_sel_iod  ? {2'h0, iodat_q[rd_ch]}
                       : rd_sel_func ? func_q[rd_ch]
                       : rd_sel_cond ? cond_q[rd_ch]
                       : 8'h00;
  wire [7:0]  rd_byte  = rd_rt       ? rt_data
                       : rd_sel_chen ? {4'h0, chen_q}
                       : rd_sel_mask ? mask_q
                       : rd_sel_dir  ? dir_rd
                       : any_en      ? ch_rd
                       : 8'h00;

  always_comb begin
    case (rd_state_q)
      RD_IDLE: rd_state_d = ar_hs ? RD_RESP : RD_IDLE;
      RD_RESP: rd_state_d = s_axi_rready_i ? RD_IDLE : RD_RESP;
      default: rd_state_d = RD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rd_state_q <= RD_IDLE;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= RESP_OKAY;
    end else begin
      rd_state_q <= rd_state_d;
      arready_q  <= (rd_state_d == RD_IDLE);
      rvalid_q   <= (rd_state_d == RD_RESP);
      if (ar_hs) begin
        rdata_q <= {24'h00_0000, rd_ok ? rd_byte : 8'h00};
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  realtime_change_irq u_rt_irq (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .data_i    (rt_data),
    .mask_i    (mask_q),
    .clear_i   (rt_clear),
    .irq_n_o   (realtime_irq_n_o)
  );

  // Per-channel storage and decoded controls.
  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    wire             ch_wr = wr_en & chen_q[c];
    wire [4:0]       isn   = gain_q[c][4:0];
    wire [5:0]       isn_signed = {1'b0, isn} - ISN_OFFSET;
    chan_ctrl_t      ctrl_d;
    line_io_drive_t  drive_d;

    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        gain_q[c]  <= RST_REG;
        iodat_q[c] <= RST_REG[5:0];
        dir_q[c]   <= RST_REG[N_PIN-1:0];
        func_q[c]  <= RST_REG;
        cond_q[c]  <= RST_REG;
      end else begin
        if (ch_wr & wr_sel_gain) begin
          gain_q[c] <= w_byte_q;
        end
        if (ch_wr & wr_sel_iod) begin
          iodat_q[c] <= w_byte_q[5:0];
        end
        if (ch_wr & wr_sel_dir) begin
          dir_q[c] <= w_byte_q[N_PIN-1:0];
        end
        if (ch_wr & wr_sel_func) begin
          func_q[c] <= w_byte_q;
        end
        if (ch_wr & wr_sel_cond) begin
          cond_q[c] <= w_byte_q;
        end
      end
    end

    always_comb begin
      ctrl_d                        = '0;
      ctrl_d.input_atten_on         = ~gain_q[c][GAIN_ATTEN_DIS];
      ctrl_d.tx_gain_6db            = gain_q[c][GAIN_TX];
      ctrl_d.rx_loss_6db            = gain_q[c][GAIN_RX];
      ctrl_d.isn_cutoff             = (isn == ISN_CUTOFF_CODE);
      ctrl_d.isn_gain               = ctrl_d.isn_cutoff ? 6'sh00 : $signed(isn_signed);
      ctrl_d.full_digital_loopback  = (isn == ISN_LOOPBACK_CODE)
                                    | cond_q[c][OC_FULL_LB];
      ctrl_d.linear_coding          = func_q[c][OF_LINEAR];
      ctrl_d.mu_law                 = ~func_q[c][OF_LINEAR] & func_q[c][OF_MULAW];
      ctrl_d.filter_programmed      = func_q[c][5:0];
      ctrl_d.tx_path_on             = ~cond_q[c][OC_TX_CUT];
      ctrl_d.rx_path_on             = ~cond_q[c][OC_RX_CUT];
      ctrl_d.b_filter_on            = ~cond_q[c][OC_RX_CUT];
      ctrl_d.tx_highpass_on         = ~cond_q[c][OC_HPF_BYP];
      ctrl_d.rx_extra_loss          = cond_q[c][OC_RX_LOSS];
      ctrl_d.tx_interrupt_arm       = cond_q[c][OC_TX_ARM];
      ctrl_d.slot_assigner_loopback = cond_q[c][OC_TSA_LB];
      ctrl_d.rx_test_tone           = cond_q[c][OC_TONE];
      drive_d.value                 = iodat_q[c][N_PIN-1:0] & dir_q[c];
      drive_d.enable                = dir_q[c];
      drive_d.pin_one_mux_second_bit = iodat_q[c][IO_MUX_BIT] & e1_multiplex_enable_i;
    end

    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        ctrl_q[c]  <= '0;
        drive_q[c] <= '0;
      end else begin
        ctrl_q[c]  <= ctrl_d;
        drive_q[c] <= drive_d;
      end
    end

    assign chan_ctrl_o[c]     = ctrl_q[c];
    assign line_io_drive_o[c] = drive_q[c];
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

endmodule

/* File: test/host_axi_model.sv */
// Purpose: Host processor model that issues register commands over AXI4-Lite.
// Assumes: One write or one read at a time; signals change right after a rising edge.
// Notes:   Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
module host_axi_model (
  input  logic                             clk_sys_i,
  output logic [codec_cfg_pkg::ADDR_W-1:0] awaddr_o,
  output logic                             awvalid_o,
  input  logic                             awready_i,
  output logic [31:0]                      wdata_o,
  output logic [3:0]                       wstrb_o,
  output logic                             wvalid_o,
  input  logic                             wready_i,
  input  logic [1:0]                       bresp_i,
  input  logic                             bvalid_i,
  output logic                             bready_o,
  output logic [codec_cfg_pkg::ADDR_W-1:0] araddr_o,
  output logic                             arvalid_o,
  input  logic                             arready_i,
  input  logic [31:0]                      rdata_i,
  input  logic [1:0]                       rresp_i,
  input  logic                             rvalid_i,
  output logic                             rready_o
);
  import codec_cfg_pkg::*;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  task automatic wr(input logic [7:0] c, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk_sys_i);
    awaddr_o  <= {c, 2'b00};
    wdata_o   <= {24'h000000, d};
    wstrb_o   <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o  <= ~awaddr_o;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o  <= ~wdata_o;
      end
    end while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk_sys_i);
    araddr_o  <= {c, 2'b00};
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o  <= ~araddr_o;
      end
    end while (!rvalid_i);
    d = rdata_i[7:0];
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule

/* File: test/codec_cfg_sva.sv */
// Purpose: Port-level checks of the channel configuration bank.
// Assumes: Channel zero is representative of every channel's decode.
// Notes:   Attached by bind from the bench top file.
`timescale 1ns/1ps
module codec_cfg_sva (
  input logic                          clk_sys_i,
  input logic                          reset_i,
  input logic                          s_axi_awvalid_i,
  input logic                          s_axi_awready_o,
  input logic                          s_axi_wvalid_i,
  input logic                          s_axi_wready_o,
  input logic                          s_axi_bvalid_o,
  input logic                          s_axi_arvalid_i,
  input logic                          s_axi_arready_o,
  input logic [31:0]                   s_axi_rdata_o,
  input logic                          s_axi_rvalid_o,
  input logic                          s_axi_rready_i,
  input logic                          e1_multiplex_enable_i,
  input logic [7:0]                    realtime_pin_i,
  input codec_cfg_pkg::chan_ctrl_t     chan_ctrl_o [codec_cfg_pkg::N_CH],
  input codec_cfg_pkg::line_io_drive_t line_io_drive_o [codec_cfg_pkg::N_CH],
  input logic                          realtime_irq_n_o
);
  import codec_cfg_pkg::*;
  logic [7:0] pin_q;
  logic [3:0] since_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Counts cycles since the real-time pins last changed, saturating.
  always_ff @(posedge clk_sys_i) begin
    pin_q   <= realtime_pin_i;
    since_q <= reset_i ? 4'hf : (realtime_pin_i != pin_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
  end
  wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o) else $error("late write answer");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("late read answer");
  rd_release_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer not released");
  rdata_upper_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  cutoff_gain_a: assert property (chan_ctrl_o[0].isn_cutoff |-> chan_ctrl_o[0].isn_gain == 6'h00)
    else $error("cutoff with nonzero gain");
  loop_code_a: assert property (!$past(reset_i) && !chan_ctrl_o[0].isn_cutoff
    && chan_ctrl_o[0].isn_gain == 6'h00 |-> chan_ctrl_o[0].full_digital_loopback)
    else $error("scaling code sixteen without loopback");
  bfilter_cut_a: assert property (!chan_ctrl_o[0].rx_path_on |-> !chan_ctrl_o[0].b_filter_on)
    else $error("b filter on during receive cutoff");
  drive_dir_a: assert property ((line_io_drive_o[0].value & ~line_io_drive_o[0].enable) == 5'h00)
    else $error("input pin driven");
  mux_gate_a: assert property (!e1_multiplex_enable_i && !$past(e1_multiplex_enable_i)
    |-> !line_io_drive_o[0].pin_one_mux_second_bit) else $error("mux bit without e1");
  law_pick_a: assert property (chan_ctrl_o[0].mu_law |-> !chan_ctrl_o[0].linear_coding)
    else $error("mu law with linear coding");
  irq_cause_a: assert property ($fell(realtime_irq_n_o) |-> since_q <= 4'd6)
    else $error("interrupt without pin change");
  write_c: cover property (s_axi_bvalid_o);
  read_c: cover property (s_axi_rvalid_o);
  irq_c: cover property ($fell(realtime_irq_n_o));
endmodule

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the channel configuration bank.
// Assumes: Host model issues the bus cycles; bench drives line-side levels.
// Notes:   Only channels zero, one and three are observed in detail.
`timescale 1ns/1ps
module tb_top;
  import codec_cfg_pkg::*;
  logic clk_sys_i, reset_i, awv, awr, wv, wr_o, bv, br, arv, arr, rv, rr;
  logic [ADDR_W-1:0] awa, ara;
  logic [31:0] wd, rdt;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, resp;
  logic e1 = 1'b0, sync_fail = 1'b0, irq_n;
  logic [3:0] active = 4'h0;
  logic [7:0] pins = 8'h00, rdv;
  chan_ctrl_t ctrl [N_CH];
  line_io_drive_t io [N_CH];
  int errors = 0;
  int checked = 0;
  logic [7:0] rst_code [7] = '{8'h4b, 8'h51, 8'h53, 8'h55, 8'h61, 8'h6d, 8'h71};
  logic [7:0] rst_exp [7] = '{8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
  host_axi_model host_axi_model_inst (.clk_sys_i, .awaddr_o(awa), .awvalid_o(awv),
    .awready_i(awr), .wdata_o(wd), .wstrb_o(ws), .wvalid_o(wv), .wready_i(wr_o),
    .bresp_i(bresp), .bvalid_i(bv), .bready_o(br), .araddr_o(ara), .arvalid_o(arv),
    .arready_i(arr), .rdata_i(rdt), .rresp_i(rresp), .rvalid_i(rv), .rready_o(rr));
  codec_channel_config_regs codec_channel_config_regs_inst (.clk_sys_i, .reset_i,
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdt), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rr), .e1_multiplex_enable_i(e1), .channel_active_i(active),
    .clock_sync_fail_i(sync_fail), .realtime_pin_i(pins), .chan_ctrl_o(ctrl),
    .line_io_drive_o(io), .realtime_irq_n_o(irq_n));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host_axi_model_inst.wr(c, d, resp);
    chk(resp, RESP_OKAY);
    @(negedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] c);
    host_axi_model_inst.rd(c, rdv, resp);
    chk(resp, RESP_OKAY);
  endtask
  function automatic logic [15:0] gain_v(chan_ctrl_t c);
    return {5'h0, c.input_atten_on, c.tx_gain_6db, c.rx_loss_6db, c.isn_gain, c.isn_cutoff,
      c.full_digital_loopback};
  endfunction
  function automatic logic [15:0] cond_v(chan_ctrl_t c);
    return {7'h0, c.tx_path_on, c.rx_path_on, c.b_filter_on, c.tx_highpass_on, c.rx_extra_loss,
      c.tx_interrupt_arm, c.slot_assigner_loopback, c.full_digital_loopback, c.rx_test_tone};
  endfunction
  function automatic logic [15:0] io_v(line_io_drive_t p);
    return {5'h0, p.value, p.enable, p.pin_one_mux_second_bit};
  endfunction
  task automatic give_verdict();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    errors++;
    give_verdict();
  end
  initial begin
    reset_i = 1'b1;
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(rst_code[i]);
      chk(rdv, rst_exp[i]);
    end
    chk(cond_v(ctrl[0]), 16'h1e0);
    $display("test reset done");
    wr(8'h50, 8'hd0);
    chk(gain_v(ctrl[0]), 16'h201);
    wr(8'h50, 8'h23);
    chk(gain_v(ctrl[3]), 16'h5cc);
    rd(8'h51);
    chk(rdv, 16'h23);
    wr(8'h50, 8'h00);
    chk(gain_v(ctrl[0]), 16'h402);
    wr(8'h60, 8'he5);
    chk({ctrl[0].linear_coding, ctrl[0].mu_law, ctrl[0].filter_programmed}, 16'ha5);
    wr(8'h60, 8'h5a);
    chk({ctrl[1].linear_coding, ctrl[1].mu_law, ctrl[1].filter_programmed}, 16'h5a);
    wr(8'h70, 8'haa);
    chk(cond_v(ctrl[0]), 16'h0ca);
    wr(8'h70, 8'h55);
    chk(cond_v(ctrl[0]), 16'h135);
    $display("test decode done");
    wr(8'h52, 8'h3f);
    wr(8'h54, 8'h05);
    chk(io_v(io[0]), 16'h14a);
    @(posedge clk_sys_i) e1 <= 1'b1;
    @(posedge clk_sys_i) active <= 4'h1;
    repeat (2) @(posedge clk_sys_i);
    chk(io_v(io[0]), 16'h14b);
    rd(8'h55);
    chk(rdv, 16'h45);
    wr(8'h54, 8'h1a);
    chk(io_v(io[0]), 16'h6b5);
    rd(8'h53);
    chk(rdv, 16'h3f);
    $display("test line pins done");
    wr(8'h4a, 8'h01);
    wr(8'h70, 8'h00);
    chk({ctrl[0].rx_test_tone, ctrl[1].rx_test_tone}, 16'h1);
    wr(8'h4a, 8'h00);
    @(posedge clk_sys_i) sync_fail <= 1'b1;
    wr(8'h6c, 8'hfe);
    rd(8'h55);
    chk(rdv, 16'h20);
    rd(8'h6d);
    chk(rdv, 16'hfe);
    wr(8'h4a, 8'h0f);
    $display("test enables done");
    @(posedge clk_sys_i) pins <= 8'h02;
    repeat (8) @(posedge clk_sys_i);
    chk(irq_n, 16'h1);
    @(posedge clk_sys_i) pins <= 8'h03;
    repeat (8) @(posedge clk_sys_i);
    chk(irq_n, 16'h0);
    rd(8'h4f);
    chk(rdv, 16'h03);
    @(negedge clk_sys_i);
    chk(irq_n, 16'h1);
    host_axi_model_inst.rd(8'h7f, rdv, resp);
    chk(resp, RESP_SLVERR);
    host_axi_model_inst.wr(8'h51, 8'h00, resp);
    chk(resp, RESP_SLVERR);
    $display("test interrupt and refusal done");
    give_verdict();
  end
endmodule
bind codec_channel_config_regs codec_cfg_sva codec_cfg_sva_inst (.clk_sys_i, .reset_i,
  .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .e1_multiplex_enable_i, .realtime_pin_i, .chan_ctrl_o, .line_io_drive_o, .realtime_irq_n_o);
